// [dv/otp_dev_model.sv]
// behavioural memory part answering on the serial programming pins
`timescale 1ns/10ps
`default_nettype none
module otp_dev_model
  import otp_prog_pkg::*;
#(
  parameter logic [13:0] DEV_ID = 14'h2C5A // arbitrary value
) (
  input wire logic hv,
  input wire logic vdd,
  input wire logic sclk,
  input wire logic pin,
  output logic dev_d,
  output logic dev_oe,
  output logic viol
);
  logic [13:0] umem [256];
  logic [13:0] cmem [128];
  logic [13:0] pc = 14'h0000;
  logic [13:0] sr = 14'h0000;
  logic [13:0] word = 14'h0000;
  logic [13:0] ld = 14'h0000;
  logic [5:0] cmd = 6'h00;
  logic [4:0] cnt = 5'h00;
  logic frame = 1'b0;
  logic rd = 1'b0;
  logic loaded = 1'b0;
  realtime t_fall = 0.0;
  realtime t_beg = 0.0;
  initial begin
    dev_d = 1'b0;
    dev_oe = 1'b0;
    viol = 1'b0;
    foreach (umem[i]) umem[i] = 14'h3FFF;
    foreach (cmem[i]) cmem[i] = 14'h3FFF;
    cmem[6] = DEV_ID;
  end
  always @(posedge hv) begin
    if (sclk || pin || vdd) viol = 1'b1;
    pc = 14'h0000;
    cnt = 5'h00;
    frame = 1'b0;
    loaded = 1'b0;
    dev_oe = 1'b0;
  end
  task automatic exec();
    case (cmd)
      CMD_LOAD_CFG: begin
        pc = 14'h2000;
        frame = 1'b1;
        rd = 1'b0;
      end
      CMD_LOAD_DATA: begin
        frame = 1'b1;
        rd = 1'b0;
      end
      CMD_READ: begin
        frame = 1'b1;
        rd = 1'b1;
        word = pc[13] ? cmem[pc[6:0]] : umem[pc[7:0]];
      end
      CMD_INC: pc = {pc[13], pc[12:0] + 13'h0001};
      CMD_BEGIN: begin
        if (!loaded) viol = 1'b1;
        if (pc[13] && pc[7:0] > 8'h03 && pc[7:0] != 8'h07) viol = 1'b1;
        loaded = 1'b0;
        t_beg = $realtime;
        if (pc[13]) cmem[pc[6:0]] = cmem[pc[6:0]] & ld;
        else umem[pc[7:0]] = umem[pc[7:0]] & ld;
      end
      CMD_END: if ($realtime - t_beg < 99000.0) viol = 1'b1;
      default: viol = 1'b1;
    endcase
  endtask
  always @(posedge sclk) if (hv && vdd) begin
    if (cnt == 5'h00 && $realtime - t_fall < 990.0) viol = 1'b1;
    if (frame && rd && cnt != 5'h00) begin
      dev_oe = 1'b1;
      dev_d = (cnt == 5'h0F) ? 1'b0 : word[cnt - 5'h01];
    end
  end
  always @(negedge sclk) if (hv && vdd) begin
    t_fall = $realtime;
    cnt = cnt + 5'h01;
    if (!frame) begin
      cmd = {pin, cmd[5:1]};
      if (cnt == 5'h06) begin
        cnt = 5'h00;
        exec();
      end
    end else begin
      if (cnt >= 5'h02 && cnt <= 5'h0F) sr = {pin, sr[13:1]};
      if (cnt == 5'h10) begin
        cnt = 5'h00;
        frame = 1'b0;
        if (rd) begin
          dev_oe = 1'b0;
          // released line shows no stale value
          dev_d = ~dev_d;
        end else begin
          ld = sr;
          loaded = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/otp_programmer_tb.sv]
// self-checking bench for the serial programmer against a behavioural part
`timescale 1ns/10ps
`default_nettype none
module otp_programmer_tb
  import otp_prog_pkg::*;
;
  localparam logic [13:0] DEV_ID = 14'h2C5A; // arbitrary value
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic rd_ready = 1'b0;
  req_t req = '0;
  logic req_ready, req_err, rd_valid, in_mode, hv, supply_en, sclk;
  logic d_o, d_oe, dev_d, dev_oe, viol, pin;
  logic [DATA_W-1:0] rd_data;
  int failures = 0;
  int cmp_count = 0;
  // both ends driving the data pin at once would hide a turnaround fault
  logic clash = 1'b0;
  always @(negedge clk_sys) if (dev_oe && d_oe) clash = 1'b1;
  assign pin = d_oe ? d_o : dev_d;
  always #12.5 clk_sys = ~clk_sys;
  otp_programmer i_dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .req_err(req_err), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .in_mode(in_mode),
    .master_clear_pin_hv(hv), .supply_en(supply_en), .serial_prog_clock_pin(sclk),
    .serial_prog_data_pin_i(pin), .serial_prog_data_pin_o(d_o),
    .serial_prog_data_pin_oe(d_oe));
  otp_dev_model #(.DEV_ID(DEV_ID)) i_dev (.hv(hv), .vdd(supply_en), .sclk(sclk),
    .pin(pin), .dev_d(dev_d), .dev_oe(dev_oe), .viol(viol));
  task automatic close_out();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  // called at a falling edge; holds the request until it is taken
  task automatic send(input op_t op, input logic [13:0] d, input logic exp_err);
    logic err;
    int n;
    n = 0;
    req.op = op;
    req.data = d;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 9000) check("req_ready", 14'h0001, {13'h0, req_ready});
    @(negedge clk_sys);
    req_valid = 1'b0;
    req.op = OP_INC;
    err = req_err;
    @(negedge clk_sys);
    err = err | req_err;
    check("req_err", {13'h0, exp_err}, {13'h0, err});
    n = 0;
    while (req_ready !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 9000) check("req_ready", 14'h0001, {13'h0, req_ready});
  endtask
  task automatic pop(input logic [13:0] exp);
    check("rd_valid", 14'h0001, {13'h0, rd_valid});
    check("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(negedge clk_sys);
    rd_ready = 1'b0;
    // one idle edge so a following pop does not raise ready in the same step
    @(negedge clk_sys);
  endtask
  task automatic rd_word(input logic [13:0] exp);
    send(OP_READ, 14'h0000, 1'b0);
    pop(exp);
  endtask
  task automatic t_entry();
    send(OP_INC, 14'h0000, 1'b1);
    send(OP_ENTER, 14'h0000, 1'b0);
    check("in_mode", 14'h0001, {13'h0, in_mode});
    check("supply_en", 14'h0001, {13'h0, supply_en});
    send(OP_ENTER, 14'h0000, 1'b1);
  endtask
  task automatic t_user();
    send(OP_PROGRAM, 14'h0000, 1'b1);
    send(OP_LOAD_DATA, 14'h2A5C, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b1);
    rd_word(14'h2A5C);
    send(OP_INC, 14'h0000, 1'b0);
    send(OP_LOAD_DATA, 14'h1555, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b0);
    rd_word(14'h1555);
  endtask
  // receiver stalls: two words wait, a third read is held off
  task automatic t_buffer();
    send(OP_READ, 14'h0000, 1'b0);
    send(OP_READ, 14'h0000, 1'b0);
    req.op = OP_READ;
    req_valid = 1'b1;
    #1;
    check("req_ready", 14'h0000, {13'h0, req_ready});
    @(negedge clk_sys);
    req_valid = 1'b0;
    req.op = OP_INC;
    pop(14'h1555);
    pop(14'h1555);
    check("rd_valid", 14'h0000, {13'h0, rd_valid});
  endtask
  task automatic t_config();
    send(OP_LOAD_CFG, 14'h0ABC, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b0);
    rd_word(14'h0ABC);
    repeat (6) send(OP_INC, 14'h0000, 1'b0);
    rd_word(DEV_ID);
    send(OP_INC, 14'h0000, 1'b0);
    send(OP_LOAD_DATA, 14'h3F7F, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b0);
    rd_word(14'h3F7F);
    send(OP_INC, 14'h0000, 1'b0);
    send(OP_LOAD_DATA, 14'h0000, 1'b0);
    send(OP_PROGRAM, 14'h0000, 1'b1);
  endtask
  task automatic t_exit();
    send(OP_EXIT, 14'h0000, 1'b0);
    check("in_mode", 14'h0000, {13'h0, in_mode});
    check("supply_en", 14'h0000, {13'h0, supply_en});
    check("hv", 14'h0000, {13'h0, hv});
    send(OP_ENTER, 14'h0000, 1'b0);
    rd_word(14'h2A5C);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    t_entry();
    t_user();
    t_buffer();
    t_config();
    t_exit();
    check("viol", 14'h0000, {13'h0, viol});
    check("clash", 14'h0000, {13'h0, clash});
    close_out();
  end
  // whole run is under 1 ms of clock; the limit leaves about twice that
  initial begin
    #2000000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire

// [logic/otp_prog_pkg.sv]
// constants and types for the serial one-time-programmable memory programmer
package otp_prog_pkg;
  localparam int CLK_MHZ = 40;
  // serial clock half period: read data is valid 200 ns after the rising edge
  localparam int HALF_NS = 300;
  localparam int GAP_NS = 1000;
  localparam int PULSE_NS = 100000;
  localparam int ENTRY_NS = 5000;
  localparam logic [11:0] HALF_CYC = 12'((HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] GAP_CYC = 12'((GAP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] PULSE_CYC = 12'((PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] ENTRY_CYC = 12'((ENTRY_NS * CLK_MHZ + 999) / 1000);
  localparam int DATA_W = 14;
  localparam int BUF_DEPTH = 2;
  localparam logic [4:0] CMD_BITS = 5'h06;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_READ = 6'h04;
  localparam logic [5:0] CMD_INC = 6'h06;
  localparam logic [5:0] CMD_BEGIN = 6'h08;
  localparam logic [5:0] CMD_END = 6'h0E;
  // configuration-space offsets that may be programmed
  localparam logic [7:0] ID_LAST_OFF = 8'h03;
  localparam logic [7:0] CFG_WORD_OFF = 8'h07;

  typedef enum logic [2:0] {
    OP_ENTER, OP_EXIT, OP_LOAD_CFG, OP_LOAD_DATA, OP_READ, OP_INC, OP_PROGRAM
  } op_t;

  typedef struct packed {
    op_t op;
    logic [DATA_W-1:0] data;
  } req_t;
endpackage

// [logic/otp_programmer.sv]
// host-side serial programmer that drives the memory part's program/verify pins
//
// Behaviour
// R1 - pins low, high voltage first, then supply
// R2 - device resets its own logic on entry
// R3 - device starts addressing user memory
// R4 - command is six clocks, LSB first
// R5 - wait one microsecond before data frame
// R6 - frame: start, 14 data bits, stop
// R7 - read data from second frame cycle
// R8 - one microsecond gap before next command
// R9 - change data on rise, sample on fall
// R10 - device decodes the six command codes
// R11 - load configuration jumps to configuration base
// R12 - configuration space left only by exiting mode
// R13 - device counter wraps within each space
// R14 - unimplemented addresses alias into implemented ones
// R15 - four ID words readable under protection
// R16 - device drives data pin during read window
// R17 - increment command advances device counter
// R18 - load precedes every begin programming
// R19 - begin programming, 100 us, end programming
// R20 - end programming stops the write
// R21 - programmed configuration bits read zero
// R22 - program only ID and configuration word
// R23 - device ID readable at offset six
// R24 - start and stop bits carry no data
`timescale 1ns/10ps
`default_nettype none
module otp_programmer
  import otp_prog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire req_t req,
  output logic req_err,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic in_mode,
  output logic master_clear_pin_hv,
  output logic supply_en,
  output logic serial_prog_clock_pin,
  input wire logic serial_prog_data_pin_i,
  output logic serial_prog_data_pin_o,
  output logic serial_prog_data_pin_oe
);
  typedef enum {S_OFF, S_VPP, S_VDD, S_IDLE, S_CMD, S_GAP, S_FRAME, S_PULSE, S_EXIT} st_t;

  st_t st_q, nxt_q;
  op_t op_q;
  logic [11:0] div_q, wait_q;
  logic [4:0] bit_q, len_q;
  logic [15:0] tx_q, rx_q;
  logic [DATA_W-1:0] data_q;
  logic [7:0] off_q;
  logic loaded_q, cfg_q, err_q, push_q;
  logic din_s1_q, din_s2_q;
  logic buf_in_ready, req_fire, tick, last_fall, prog_ok;

  assign tick = (div_q == HALF_CYC - 12'h001);
  assign last_fall = tick & serial_prog_clock_pin & (bit_q == len_q - 5'h01);
  // reads only start when the buffer has room, so a stalled reader loses nothing
  assign req_ready = ((st_q == S_IDLE) | (st_q == S_OFF)) & ((req.op != OP_READ) | buf_in_ready);
  assign req_fire = req_valid & req_ready;
  assign prog_ok = loaded_q & (!cfg_q | off_q <= ID_LAST_OFF | off_q == CFG_WORD_OFF); // [R18] [R22]
  assign req_err = err_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= serial_prog_data_pin_i;
      din_s2_q <= din_s1_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
    end else if ((st_q == S_CMD || st_q == S_FRAME) && !tick) begin
      div_q <= div_q + 12'h001;
    end else begin
      div_q <= '0;
    end
  end

  // address shadow: the part itself wraps and aliases, this tracks the space and an unaliased 8-bit offset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loaded_q <= 1'b0;
      cfg_q <= 1'b0;
      off_q <= '0;
    end else if (st_q == S_EXIT) begin
      loaded_q <= 1'b0;
      cfg_q <= 1'b0; // [R12]
      off_q <= '0;
    end else if (req_fire && st_q == S_IDLE) begin
      case (req.op)
        OP_LOAD_CFG: begin
          cfg_q <= 1'b1; // [R11]
          off_q <= '0;
          loaded_q <= 1'b1;
        end
        OP_LOAD_DATA: loaded_q <= 1'b1;
        OP_INC: off_q <= off_q + 8'h01;
        OP_PROGRAM: begin
          if (prog_ok) begin
            loaded_q <= 1'b0; // [R18]
          end
        end
        default: loaded_q <= loaded_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_OFF;
      nxt_q <= S_IDLE;
      op_q <= OP_ENTER;
      wait_q <= '0;
      bit_q <= '0;
      len_q <= CMD_BITS;
      tx_q <= '0;
      rx_q <= '0;
      data_q <= '0;
      err_q <= 1'b0;
      push_q <= 1'b0;
      in_mode <= 1'b0;
      master_clear_pin_hv <= 1'b0;
      supply_en <= 1'b0;
      serial_prog_clock_pin <= 1'b0;
      serial_prog_data_pin_o <= 1'b0;
      serial_prog_data_pin_oe <= 1'b1;
    end else begin
      err_q <= 1'b0;
      push_q <= 1'b0;
      case (st_q)
        S_OFF: begin
          serial_prog_clock_pin <= 1'b0;
          serial_prog_data_pin_o <= 1'b0;
          serial_prog_data_pin_oe <= 1'b1;
          wait_q <= '0;
          if (req_fire) begin
            if (req.op == OP_ENTER) begin
              master_clear_pin_hv <= 1'b1; // [R1]
              st_q <= S_VPP;
            end else begin
              err_q <= 1'b1;
            end
          end
        end
        S_VPP: begin
          wait_q <= wait_q + 12'h001;
          if (wait_q == ENTRY_CYC - 12'h001) begin
            supply_en <= 1'b1; // [R1]
            wait_q <= '0;
            st_q <= S_VDD;
          end
        end
        S_VDD: begin
          wait_q <= wait_q + 12'h001;
          if (wait_q == ENTRY_CYC - 12'h001) begin
            in_mode <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          bit_q <= '0;
          len_q <= CMD_BITS; // [R4]
          if (req_fire) begin
            op_q <= req.op;
            data_q <= req.data;
            nxt_q <= S_IDLE;
            st_q <= S_CMD;
            case (req.op)
              OP_LOAD_CFG: begin
                tx_q <= {10'h000, CMD_LOAD_CFG};
                nxt_q <= S_FRAME;
              end
              OP_LOAD_DATA: begin
                tx_q <= {10'h000, CMD_LOAD_DATA};
                nxt_q <= S_FRAME;
              end
              OP_READ: begin
                tx_q <= {10'h000, CMD_READ};
                nxt_q <= S_FRAME;
              end
              OP_INC: tx_q <= {10'h000, CMD_INC};
              OP_PROGRAM: begin
                tx_q <= {10'h000, CMD_BEGIN};
                nxt_q <= S_PULSE; // [R19]
                if (!prog_ok) begin
                  err_q <= 1'b1;
                  st_q <= S_IDLE;
                end
              end
              OP_EXIT: begin
                wait_q <= '0;
                in_mode <= 1'b0;
                supply_en <= 1'b0;
                st_q <= S_EXIT;
              end
              default: begin
                err_q <= 1'b1;
                st_q <= S_IDLE;
              end
            endcase
          end
        end
        S_CMD, S_FRAME: begin
          if (tick) begin
            if (!serial_prog_clock_pin) begin
              serial_prog_clock_pin <= 1'b1;
              serial_prog_data_pin_o <= tx_q[0]; // [R9]
              tx_q <= {1'b0, tx_q[15:1]};
            end else begin
              serial_prog_clock_pin <= 1'b0;
              rx_q <= {din_s2_q, rx_q[15:1]}; // [R9] [R7]
              bit_q <= bit_q + 5'h01;
              if (last_fall) begin
                wait_q <= '0;
                st_q <= S_GAP;
                if (st_q == S_FRAME) begin
                  nxt_q <= S_IDLE;
                  serial_prog_data_pin_o <= 1'b0;
                  serial_prog_data_pin_oe <= 1'b1;
                  push_q <= (op_q == OP_READ);
                end
              end
            end
          end
        end
        S_GAP: begin
          wait_q <= wait_q + 12'h001;
          bit_q <= '0;
          if (wait_q == GAP_CYC - 12'h001) begin // [R5] [R8]
            wait_q <= '0;
            st_q <= nxt_q;
            if (nxt_q == S_FRAME) begin
              len_q <= FRAME_BITS; // [R6]
              tx_q <= {1'b0, data_q, 1'b0}; // [R6] [R24]
              // host lets go of the pin for the whole read frame
              serial_prog_data_pin_oe <= (op_q != OP_READ); // [R7]
            end
          end
        end
        S_PULSE: begin
          wait_q <= wait_q + 12'h001;
          if (wait_q == PULSE_CYC - 12'h001) begin // [R19]
            tx_q <= {10'h000, CMD_END};
            len_q <= CMD_BITS;
            nxt_q <= S_IDLE;
            st_q <= S_CMD;
          end
        end
        S_EXIT: begin
          wait_q <= wait_q + 12'h001;
          if (wait_q == ENTRY_CYC - 12'h001) begin
            master_clear_pin_hv <= 1'b0;
            st_q <= S_OFF;
          end
        end
        default: st_q <= S_OFF;
      endcase
    end
  end

  word_buf #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_rd_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push_q),
    .in_ready(buf_in_ready),
    .in_data(rx_q[14:1]),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // helper: cycles since the last falling edge of the serial clock
  logic [11:0] low_cnt_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_cnt_q <= 12'hFFF;
    end else if ($fell(serial_prog_clock_pin)) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != 12'hFFF) begin
      low_cnt_q <= low_cnt_q + 12'h001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_entry_pins_low: assert property ((st_q == S_VPP) |-> !serial_prog_clock_pin && // [R1]
      serial_prog_data_pin_oe && !serial_prog_data_pin_o)
    else $error("pins not low during mode entry");
  a_supply_after_hv: assert property ($rose(supply_en) |-> master_clear_pin_hv && // [R1]
      $past(master_clear_pin_hv, 8))
    else $error("supply raised before high voltage");
  a_cmd_six_bits: assert property ((st_q == S_CMD) && last_fall |-> len_q == 5'h06 && // [R4]
      bit_q == 5'h05)
    else $error("command not six clocks");
  a_frame_sixteen: assert property ((st_q == S_FRAME) && last_fall |-> bit_q == 5'h0F) // [R6]
    else $error("frame not sixteen clocks");
  a_gap_before_start: assert property (($rose(serial_prog_clock_pin) && bit_q == 5'h00) // [R5] [R8]
      |-> $past(low_cnt_q) >= GAP_CYC)
    else $error("gap before command or frame too short");
  a_data_on_rise: assert property ((st_q == S_CMD || st_q == S_FRAME) && // [R9]
      $changed(serial_prog_data_pin_o) |-> $rose(serial_prog_clock_pin))
    else $error("data changed away from rising edge");
  a_read_released: assert property ((st_q == S_FRAME && op_q == OP_READ) |-> // [R7]
      !serial_prog_data_pin_oe)
    else $error("host drives pin during read frame");
  a_prog_needs_load: assert property ((req_fire && st_q == S_IDLE && req.op == OP_PROGRAM && // [R18]
      !loaded_q) |=> err_q && st_q == S_IDLE)
    else $error("begin programming without a load");
  a_pulse_length: assert property ($fell(st_q == S_PULSE) |-> // [R19]
      $past(wait_q) == PULSE_CYC - 12'h001)
    else $error("programming pulse ended early");
  a_pulse_end_cmd: assert property ((st_q == S_PULSE && wait_q == PULSE_CYC - 12'h001) |=> // [R19]
      st_q == S_CMD && tx_q[5:0] == CMD_END)
    else $error("end programming not sent after pulse");

  c_read_word: cover property (push_q ##1 rd_valid);
  c_buffer_full: cover property (!buf_in_ready);
  c_prog_pulse: cover property (st_q == S_PULSE ##1 st_q == S_CMD);
  c_exit_mode: cover property (st_q == S_EXIT ##1 st_q == S_OFF);
endmodule
`default_nettype wire

// [logic/word_buf.sv]
// small valid/ready buffer for read-back words
`timescale 1ns/10ps
`default_nettype none
module word_buf #(
  parameter int W = 14,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
